// *** src/ccr_pkg.sv ***
// Constants for the clock generator control register bank.
// Assumes a byte-wide register map reached through an SMBus slave port.
package ccr_pkg;

  // Register byte offsets
  localparam logic [6:0] CCR_OFS_CLK_ENABLE_C   = 7'h02;
  localparam logic [6:0] CCR_OFS_STOP_ELIG      = 7'h03;
  localparam logic [6:0] CCR_OFS_CPU_PD_DRIVE   = 7'h04;
  localparam logic [6:0] CCR_OFS_REF_DRIVE_MODE = 7'h05;
  localparam logic [6:0] CCR_OFS_TEST_STOP      = 7'h06;

  // Field positions
  localparam int CCR_BIT_CLK48_EN     = 0;
  localparam int CCR_BIT_CPU_PD_LO    = 4;
  localparam int CCR_BIT_REF_STOP_TS  = 6;
  localparam int CCR_BIT_REF_PD_TS    = 5;
  localparam int CCR_BIT_TEST_SEL     = 7;
  localparam int CCR_BIT_TEST_MODE    = 6;
  localparam int CCR_BIT_REF_STRONG   = 4;
  localparam int CCR_BIT_SW_RUN       = 3;
  localparam int CCR_BIT_CMD_BYTE     = 7;

  // Power-up values
  localparam logic       CCR_RST_CLK48_EN   = 1'b1;
  localparam logic [7:0] CCR_RST_STOP_ELIG  = 8'h00;
  localparam logic [3:0] CCR_RST_CPU_PD     = 4'h0;
  localparam logic       CCR_RST_REF_STOP_TS = 1'b0;
  localparam logic       CCR_RST_REF_PD_TS  = 1'b0;
  localparam logic       CCR_RST_TEST_SEL   = 1'b0;
  localparam logic       CCR_RST_TEST_MODE  = 1'b0;
  localparam logic       CCR_RST_REF_STRONG = 1'b1;
  localparam logic       CCR_RST_SW_RUN     = 1'b1;

  // Bus constants
  localparam logic [6:0] CCR_SLAVE_ADDR  = 7'h69;
  localparam logic [7:0] CCR_BLOCK_COUNT = 8'h08;
  localparam logic [3:0] CCR_BITS_BYTE   = 4'h8;

  typedef enum logic [2:0] {
    CCR_IDLE  = 3'b000,
    CCR_ADDR  = 3'b001,
    CCR_WBYTE = 3'b011,
    CCR_ACK   = 3'b010,
    CCR_RBYTE = 3'b110,
    CCR_RACK  = 3'b111
  } ccr_state_t;

  typedef enum logic [1:0] {
    CCR_PH_CMD   = 2'h0,
    CCR_PH_COUNT = 2'h1,
    CCR_PH_DATA  = 2'h2
  } ccr_phase_t;

endpackage : ccr_pkg

// *** src/ccr_regs.sv ***
// Control register bytes 2 to 6 of a clock generator, with its SMBus slave port.
// Assumes SMBus clock and data inputs are synchronous to mclk and held for
// several mclk cycles per level; data pin is open drain, driven low when oe is high.
//
// Summary of operation
// R1: Byte 2 bit 0 enables the 48 MHz output; powers up enabled.
// R2: Byte 3 bits 7..5 make free-running bus clocks stoppable; power up 0.
// R3: Byte 3 bits 4..0 make reference pairs stoppable; power up 0.
// R4: Byte 4 bits 7..4 pick CPU pair power-down mode: driven or tri-state.
// R5: Byte 5 bit 6 picks stopped reference pair mode: driven or tri-state.
// R6: Byte 5 bit 5 picks power-down mode of all reference pairs.
// R7: Byte 6 bit 6 enters test clock mode; powers up normal.
// R8: Byte 6 bit 7 picks test output: tri-state or divided reference.
// R9: Byte 6 bit 4 sets reference output drive strength; powers up high.
// R10: Writing 0 to byte 6 bit 3 halts stoppable clocks cleanly.
// R11: Writing 1 to byte 6 bit 3 restarts halted clocks; powers up 1.
// R12: Byte 6 bits 2..0 read frequency-select pins caught at power good.
// R13: Command bit 7 picks block (0) or byte (1); in byte mode bits 6..0 give offset, block starts at 0.
// R14: Power-down drive mode 0 holds true pin high, complement tri-stated.
// R15: Host writes 0 to set-to-zero reserved bits, ignores other reserved reads.
// R16: Host writes never change the caught frequency-select bits.
`timescale 1ns/1ps

module ccr_regs
  import ccr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = CCR_SLAVE_ADDR
)(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       smb_clk_in,
  input  wire logic       smb_data_in,
  output logic            smb_data_out,
  output logic            smb_data_oe,
  input  wire logic       freq_select_0,
  input  wire logic       freq_select_1,
  input  wire logic       freq_select_2,
  input  wire logic       power_good_n,
  input  wire logic       power_down_in,
  output logic            clk48_out_en,
  output logic [2:0]      free_running_bus_clk_stoppable,
  output logic [4:0]      sys_ref_pair_stoppable,
  output logic [3:0]      cpu_pair_pd_tristate,
  output logic            sys_ref_pair_stop_tristate,
  output logic            sys_ref_pair_pd_tristate,
  output logic [3:0]      cpu_pair_pd_true_high,
  output logic            sys_ref_pair_pd_true_high,
  output logic            test_clk_mode,
  output logic            test_clk_div_ref,
  output logic            ref_drive_high,
  output logic            bus_clk_halt_n,
  output logic [2:0]      freq_select_latched
);

  typedef struct packed {
    ccr_state_t st;
    ccr_phase_t ph;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic       rd;
    logic       cnt_pend;
    logic [6:0] ptr;
    logic       sda_oe;
    logic       clk48_en;
    logic [7:0] stop_elig;
    logic [3:0] cpu_pd;
    logic       ref_stop_ts;
    logic       ref_pd_ts;
    logic       test_sel;
    logic       test_mode;
    logic       ref_strong;
    logic       sw_run;
    logic [2:0] fs;
    logic       fs_caught;
    logic [3:0] cpu_hold;
    logic       ref_hold;
  } ccr_state_s_t;

  ccr_state_s_t s_reg;
  ccr_state_s_t s_next;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [7:0] rd_byte;

  assign scl_rise   = smb_clk_in & ~s_reg.scl_q;
  assign scl_fall   = ~smb_clk_in & s_reg.scl_q;
  assign start_seen = smb_clk_in & s_reg.scl_q & s_reg.sda_q & ~smb_data_in;
  assign stop_seen  = smb_clk_in & s_reg.scl_q & ~s_reg.sda_q & smb_data_in;

  // Read-back value of the byte at the pointer; bits of other banks read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (s_reg.ptr == CCR_OFS_CLK_ENABLE_C)
    begin
      rd_byte[CCR_BIT_CLK48_EN] = s_reg.clk48_en;
    end
    else if (s_reg.ptr == CCR_OFS_STOP_ELIG)
    begin
      rd_byte = s_reg.stop_elig;
    end
    else if (s_reg.ptr == CCR_OFS_CPU_PD_DRIVE)
    begin
      rd_byte[7:CCR_BIT_CPU_PD_LO] = s_reg.cpu_pd;
    end
    else if (s_reg.ptr == CCR_OFS_REF_DRIVE_MODE)
    begin
      rd_byte[CCR_BIT_REF_STOP_TS] = s_reg.ref_stop_ts;
      rd_byte[CCR_BIT_REF_PD_TS]   = s_reg.ref_pd_ts;
    end
    else if (s_reg.ptr == CCR_OFS_TEST_STOP)
    begin
      rd_byte[CCR_BIT_TEST_SEL]   = s_reg.test_sel;
      rd_byte[CCR_BIT_TEST_MODE]  = s_reg.test_mode;
      rd_byte[CCR_BIT_REF_STRONG] = s_reg.ref_strong;
      rd_byte[CCR_BIT_SW_RUN]     = s_reg.sw_run;
      rd_byte[2:0]                = s_reg.fs; // R12
    end
  end

  always_comb
  begin
    s_next       = s_reg;
    s_next.scl_q = smb_clk_in;
    s_next.sda_q = smb_data_in;

    // Straps caught once, when power good is first seen low
    if (!s_reg.fs_caught && !power_good_n)
    begin
      s_next.fs        = {freq_select_2, freq_select_1, freq_select_0}; // R12
      s_next.fs_caught = 1'b1; // R16
    end

    if (stop_seen)
    begin
      s_next.st     = CCR_IDLE;
      s_next.sda_oe = 1'b0;
    end
    else if (start_seen)
    begin
      s_next.st     = CCR_ADDR;
      s_next.bitcnt = 4'h0;
      s_next.sda_oe = 1'b0;
    end
    else
    begin
      case (s_reg.st)
        CCR_ADDR, CCR_WBYTE:
        begin
          if (scl_rise)
          begin
            s_next.shift  = {s_reg.shift[6:0], smb_data_in};
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end
          else if (scl_fall && s_reg.bitcnt == CCR_BITS_BYTE)
          begin
            s_next.st     = CCR_ACK;
            s_next.sda_oe = 1'b1;
            if (s_reg.st == CCR_ADDR)
            begin
              if (s_reg.shift[7:1] == SLAVE_ADDR)
              begin
                s_next.rd = s_reg.shift[0];
                s_next.ph = s_reg.shift[0] ? s_reg.ph : CCR_PH_CMD;
              end
              else
              begin
                s_next.st     = CCR_IDLE;
                s_next.sda_oe = 1'b0;
              end
            end
            else if (s_reg.ph == CCR_PH_CMD)
            begin
              s_next.cnt_pend = ~s_reg.shift[CCR_BIT_CMD_BYTE]; // R13
              s_next.ptr      = s_reg.shift[CCR_BIT_CMD_BYTE] ? s_reg.shift[6:0] : 7'h00; // R13
              s_next.ph       = s_reg.shift[CCR_BIT_CMD_BYTE] ? CCR_PH_DATA : CCR_PH_COUNT;
            end
            else if (s_reg.ph == CCR_PH_COUNT)
            begin
              s_next.ph       = CCR_PH_DATA;
              s_next.cnt_pend = 1'b0;
            end
            else
            begin
              s_next.ptr = s_reg.ptr + 7'h01;
              if (s_reg.ptr == CCR_OFS_CLK_ENABLE_C)
              begin
                s_next.clk48_en = s_reg.shift[CCR_BIT_CLK48_EN]; // R1
              end
              else if (s_reg.ptr == CCR_OFS_STOP_ELIG)
              begin
                s_next.stop_elig = s_reg.shift; // R2 R3
              end
              else if (s_reg.ptr == CCR_OFS_CPU_PD_DRIVE)
              begin
                s_next.cpu_pd = s_reg.shift[7:CCR_BIT_CPU_PD_LO]; // R4
              end
              else if (s_reg.ptr == CCR_OFS_REF_DRIVE_MODE)
              begin
                s_next.ref_stop_ts = s_reg.shift[CCR_BIT_REF_STOP_TS]; // R5
                s_next.ref_pd_ts   = s_reg.shift[CCR_BIT_REF_PD_TS]; // R6
              end
              else if (s_reg.ptr == CCR_OFS_TEST_STOP)
              begin
                s_next.test_sel   = s_reg.shift[CCR_BIT_TEST_SEL]; // R8
                s_next.test_mode  = s_reg.shift[CCR_BIT_TEST_MODE]; // R7
                s_next.ref_strong = s_reg.shift[CCR_BIT_REF_STRONG]; // R9
                s_next.sw_run     = s_reg.shift[CCR_BIT_SW_RUN]; // R10 R11
              end
            end
          end
        end
        CCR_ACK:
        begin
          if (scl_fall)
          begin
            s_next.bitcnt = 4'h0;
            s_next.sda_oe = 1'b0;
            s_next.st     = CCR_WBYTE;
            if (s_reg.rd)
            begin
              s_next.st = CCR_RBYTE;
              if (s_reg.cnt_pend)
              begin
                s_next.shift    = {CCR_BLOCK_COUNT[6:0], 1'b0};
                s_next.sda_oe   = ~CCR_BLOCK_COUNT[7];
                s_next.cnt_pend = 1'b0;
              end
              else
              begin
                s_next.shift  = {rd_byte[6:0], 1'b0};
                s_next.sda_oe = ~rd_byte[7];
                s_next.ptr    = s_reg.ptr + 7'h01;
              end
              s_next.bitcnt = 4'h1;
            end
          end
        end
        CCR_RBYTE:
        begin
          if (scl_fall)
          begin
            if (s_reg.bitcnt == CCR_BITS_BYTE)
            begin
              s_next.sda_oe = 1'b0;
              s_next.st     = CCR_RACK;
            end
            else
            begin
              s_next.sda_oe = ~s_reg.shift[7];
              s_next.shift  = {s_reg.shift[6:0], 1'b0};
              s_next.bitcnt = s_reg.bitcnt + 4'h1;
            end
          end
        end
        CCR_RACK:
        begin
          // Host not-acknowledge ends the read; acknowledge loads the next byte on the fall
          if (scl_rise && smb_data_in)
          begin
            s_next.st = CCR_IDLE;
          end
          else if (scl_fall)
          begin
            s_next.st     = CCR_RBYTE;
            s_next.shift  = {rd_byte[6:0], 1'b0};
            s_next.sda_oe = ~rd_byte[7];
            s_next.ptr    = s_reg.ptr + 7'h01;
            s_next.bitcnt = 4'h1;
          end
        end
        default:
        begin
          s_next.st = CCR_IDLE;
        end
      endcase
    end

    // Power-down hold: true pin driven high when drive mode is 0
    s_next.cpu_hold = {4{power_down_in}} & ~s_reg.cpu_pd; // R14
    s_next.ref_hold = power_down_in & ~s_reg.ref_pd_ts; // R14
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_reg             <= '0;
      s_reg.st          <= CCR_IDLE;
      s_reg.ph          <= CCR_PH_CMD;
      s_reg.scl_q       <= 1'b1;
      s_reg.sda_q       <= 1'b1;
      s_reg.clk48_en    <= CCR_RST_CLK48_EN; // R1
      s_reg.stop_elig   <= CCR_RST_STOP_ELIG; // R2 R3
      s_reg.cpu_pd      <= CCR_RST_CPU_PD; // R4
      s_reg.ref_stop_ts <= CCR_RST_REF_STOP_TS; // R5
      s_reg.ref_pd_ts   <= CCR_RST_REF_PD_TS; // R6
      s_reg.test_sel    <= CCR_RST_TEST_SEL; // R8
      s_reg.test_mode   <= CCR_RST_TEST_MODE; // R7
      s_reg.ref_strong  <= CCR_RST_REF_STRONG; // R9
      s_reg.sw_run      <= CCR_RST_SW_RUN; // R11
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign smb_data_out                   = 1'b0;
  assign smb_data_oe                    = s_reg.sda_oe;
  assign clk48_out_en                   = s_reg.clk48_en;
  assign free_running_bus_clk_stoppable = s_reg.stop_elig[7:5];
  assign sys_ref_pair_stoppable         = s_reg.stop_elig[4:0];
  assign cpu_pair_pd_tristate           = s_reg.cpu_pd;
  assign sys_ref_pair_stop_tristate     = s_reg.ref_stop_ts;
  assign sys_ref_pair_pd_tristate       = s_reg.ref_pd_ts;
  assign cpu_pair_pd_true_high          = s_reg.cpu_hold;
  assign sys_ref_pair_pd_true_high      = s_reg.ref_hold;
  assign test_clk_mode                  = s_reg.test_mode;
  assign test_clk_div_ref               = s_reg.test_sel;
  assign ref_drive_high                 = s_reg.ref_strong;
  // Clock gating downstream halts only at a low phase, so no runt pulse
  assign bus_clk_halt_n                 = s_reg.sw_run; // R10 R11
  assign freq_select_latched            = s_reg.fs;

endmodule : ccr_regs

// *** sim/ccr_regs_assertions.sv ***
// Concurrent checks on the control register bank ports.
// Assumes binding to ccr_regs; one clock domain, synchronous reset.
`timescale 1ns/1ps
module ccr_regs_assertions (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       smb_clk_in,
  input wire logic       smb_data_oe,
  input wire logic       power_good_n,
  input wire logic       power_down_in,
  input wire logic       clk48_out_en,
  input wire logic [2:0] free_running_bus_clk_stoppable,
  input wire logic [4:0] sys_ref_pair_stoppable,
  input wire logic [3:0] cpu_pair_pd_tristate,
  input wire logic       sys_ref_pair_stop_tristate,
  input wire logic       sys_ref_pair_pd_tristate,
  input wire logic [3:0] cpu_pair_pd_true_high,
  input wire logic       sys_ref_pair_pd_true_high,
  input wire logic       test_clk_mode,
  input wire logic       test_clk_div_ref,
  input wire logic       ref_drive_high,
  input wire logic       bus_clk_halt_n,
  input wire logic [2:0] freq_select_latched
);
  logic [18:0] cfg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  assign cfg = {clk48_out_en, free_running_bus_clk_stoppable, sys_ref_pair_stoppable,
                cpu_pair_pd_tristate, sys_ref_pair_stop_tristate, sys_ref_pair_pd_tristate,
                test_clk_mode, test_clk_div_ref, ref_drive_high, bus_clk_halt_n};
  reset_ones_a:
  assert property (disable iff (1'b0) reset |=> clk48_out_en && ref_drive_high && bus_clk_halt_n)
    else $error("reset value of an enabled field wrong");
  reset_zeros_a:
  assert property (disable iff (1'b0) reset |=> cfg[17:2] == 16'h0000 && !smb_data_oe)
    else $error("reset value of a cleared field wrong");
  pd_cpu_hold_a:
  assert property (!$past(reset) |->
    cpu_pair_pd_true_high == ({4{$past(power_down_in)}} & ~$past(cpu_pair_pd_tristate)))
    else $error("cpu pair power-down hold wrong");
  pd_ref_hold_a:
  assert property (!$past(reset) |->
    sys_ref_pair_pd_true_high == ($past(power_down_in) & ~$past(sys_ref_pair_pd_tristate)))
    else $error("reference pair power-down hold wrong");
  strap_hold_a:
  assert property (!$past(reset) && ($past(power_good_n) ||
    (!$past(reset, 2) && !$past(power_good_n, 2))) |-> $stable(freq_select_latched))
    else $error("strap copy changed");
  cfg_scl_low_a:
  assert property (!$past(reset) && !$stable(cfg) |-> !smb_clk_in && !$past(smb_clk_in))
    else $error("control field changed outside a bus clock low");
  ack_scl_low_a:
  assert property ($rose(smb_data_oe) |-> !smb_clk_in && !$past(smb_clk_in))
    else $error("data pulled while bus clock high");
  oe_hold_high_a:
  assert property (smb_clk_in && $past(smb_clk_in) |-> $stable(smb_data_oe))
    else $error("data moved while bus clock high");
endmodule : ccr_regs_assertions

bind ccr_regs ccr_regs_assertions u_chk (.mclk(mclk), .reset(reset), .smb_clk_in(smb_clk_in),
  .smb_data_oe(smb_data_oe), .power_good_n(power_good_n), .power_down_in(power_down_in),
  .clk48_out_en(clk48_out_en), .free_running_bus_clk_stoppable(free_running_bus_clk_stoppable),
  .sys_ref_pair_stoppable(sys_ref_pair_stoppable), .cpu_pair_pd_tristate(cpu_pair_pd_tristate),
  .sys_ref_pair_stop_tristate(sys_ref_pair_stop_tristate),
  .sys_ref_pair_pd_tristate(sys_ref_pair_pd_tristate),
  .cpu_pair_pd_true_high(cpu_pair_pd_true_high),
  .sys_ref_pair_pd_true_high(sys_ref_pair_pd_true_high), .test_clk_mode(test_clk_mode),
  .test_clk_div_ref(test_clk_div_ref), .ref_drive_high(ref_drive_high),
  .bus_clk_halt_n(bus_clk_halt_n), .freq_select_latched(freq_select_latched));

// *** sim/ccr_smb_host.sv ***
// SMBus host model: start, stop and nine-bit transfers, four mclk per phase.
// Assumes the data wire is resolved outside with a pull-up; sda high releases it.
`timescale 1ns/1ps
module ccr_smb_host (
  input  wire logic       mclk,
  input  wire logic       sda_wire,
  output logic            scl,
  output logic            sda,
  output logic            got_valid,
  output logic [7:0]      got_data
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    got_valid = 1'b0;
    got_data = 8'h00;
  end
  task automatic w4;
    repeat (4) @(posedge mclk);
  endtask : w4
  // Also serves as repeated start
  task automatic start;
    sda <= 1'b1;
    w4;
    scl <= 1'b1;
    w4;
    sda <= 1'b0;
    w4;
    scl <= 1'b0;
    w4;
  endtask : start
  task automatic stop;
    sda <= 1'b0;
    w4;
    scl <= 1'b1;
    w4;
    sda <= 1'b1;
    w4;
  endtask : stop
  // Data only moves while scl is low; MSB first, ninth bit is the acknowledge
  task automatic xfer(input logic [7:0] d, input logic rd, input logic last, output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = rd ? {8'hff, last} : {d, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      sda <= tx[i];
      w4;
      scl <= 1'b1;
      w4;
      rx[i] = sda_wire;
      scl <= 1'b0;
      w4;
    end
    ack = ~rx[0];
    if (rd)
    begin
      got_data <= rx[8:1];
      got_valid <= 1'b1;
      @(posedge mclk);
      got_valid <= 1'b0;
    end
  endtask : xfer
endmodule : ccr_smb_host

// *** sim/clock_gen_control_regs_tb.sv ***
// Self-checking bench for the control register bank over its SMBus port.
// Assumes ccr_smb_host as bus partner and the bound checker.
`timescale 1ns/1ps
module clock_gen_control_regs_tb;
  import ccr_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, pg_n = 1'b1, pd = 1'b0, scl, sda_h, oe, k, gv;
  logic [2:0]  fs = 3'h0, fsl = 3'h0, fr, fsq;
  logic [4:0]  srp;
  logic [3:0]  ctri, chi;
  logic [7:0]  gd;
  logic [18:0] pv;
  logic        c48, sts, pts, shi, tm, dr, rh, hn, sdo;
  logic [7:0]  sh [0:7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h18, 8'h00};
  logic [7:0]  msk [0:7] = '{8'h00, 8'h00, 8'h01, 8'hff, 8'hf0, 8'h60, 8'hd8, 8'h00};
  logic [7:0]  expq [$];
  int          bad_count = 0, n_tests = 0;
  wire         sda = sda_h & (~oe | sdo);
  always #4 mclk = ~mclk;
  ccr_smb_host host (.mclk(mclk), .sda_wire(sda), .scl(scl), .sda(sda_h), .got_valid(gv),
    .got_data(gd));
  ccr_regs DUT (.mclk(mclk), .reset(reset), .smb_clk_in(scl), .smb_data_in(sda),
    .smb_data_out(sdo), .smb_data_oe(oe), .freq_select_0(fs[0]), .freq_select_1(fs[1]),
    .freq_select_2(fs[2]), .power_good_n(pg_n), .power_down_in(pd), .clk48_out_en(c48),
    .free_running_bus_clk_stoppable(fr), .sys_ref_pair_stoppable(srp),
    .cpu_pair_pd_tristate(ctri), .sys_ref_pair_stop_tristate(sts),
    .sys_ref_pair_pd_tristate(pts), .cpu_pair_pd_true_high(chi),
    .sys_ref_pair_pd_true_high(shi), .test_clk_mode(tm), .test_clk_div_ref(dr),
    .ref_drive_high(rh), .bus_clk_halt_n(hn), .freq_select_latched(fsq));
  assign pv = {c48, fr, srp, ctri, sts, pts, tm, dr, rh, hn};
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [7:0] rb(input int o);
    return (sh[o] & msk[o]) | (o == 6 ? {5'h00, fsl} : 8'h00);
  endfunction : rb
  task automatic wait_chk;
    @(negedge mclk);
    chk(pv, {sh[2][0], sh[3], sh[4][7:4], sh[5][6:5], sh[6][6], sh[6][7], sh[6][4:3]});
    chk({chi, shi}, {{4{pd}} & ~sh[4][7:4], pd & ~sh[5][5]});
  endtask : wait_chk
  task automatic wr(input logic [6:0] o, input logic [7:0] d, input logic [6:0] a);
    host.start;
    host.xfer({a, 1'b0}, 1'b0, 1'b0, k);
    chk(k, a == CCR_SLAVE_ADDR);
    if (k)
    begin
      host.xfer({1'b1, o}, 1'b0, 1'b0, k);
      host.xfer(d, 1'b0, 1'b0, k);
      sh[o] = d;
    end
    host.stop;
    pd <= 1'($urandom);
    repeat (2) @(posedge mclk);
    wait_chk;
  endtask : wr
  task automatic rd_head(input logic [7:0] cmd);
    host.start;
    host.xfer({CCR_SLAVE_ADDR, 1'b0}, 1'b0, 1'b0, k);
    host.xfer(cmd, 1'b0, 1'b0, k);
    host.start;
    host.xfer({CCR_SLAVE_ADDR, 1'b1}, 1'b0, 1'b0, k);
  endtask : rd_head
  task automatic rd(input logic [6:0] o);
    rd_head({1'b1, o});
    expq.push_back(rb(o));
    host.xfer(8'h00, 1'b1, 1'b1, k);
    host.stop;
  endtask : rd
  task automatic blk;
    logic [7:0] d;
    host.start;
    host.xfer({CCR_SLAVE_ADDR, 1'b0}, 1'b0, 1'b0, k);
    host.xfer(8'h00, 1'b0, 1'b0, k);
    host.xfer(8'h07, 1'b0, 1'b0, k);
    for (int i = 0; i < 7; i++)
    begin
      d = 8'($urandom);
      d = d & ~(i == 5 ? 8'h10 : (i == 6 ? 8'h20 : 8'h00));
      host.xfer(d, 1'b0, 1'b0, k);
      sh[i] = d;
    end
    host.stop;
    wait_chk;
    rd_head(8'h00);
    expq.push_back(CCR_BLOCK_COUNT);
    host.xfer(8'h00, 1'b1, 1'b0, k);
    for (int i = 0; i < 8; i++)
    begin
      expq.push_back(rb(i));
      host.xfer(8'h00, 1'b1, i == 7, k);
    end
    host.stop;
  endtask : blk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge mclk)
    if (gv === 1'b1)
      chk(gd, expq.pop_front());
  initial
  begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    wrap_up;
  end
  initial
  begin
    logic [7:0] d;
    void'($urandom(32'h7e8c));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    fs <= 3'($urandom);
    @(posedge mclk);
    pg_n <= 1'b0;
    fsl = fs;
    repeat (3) @(posedge mclk);
    fs <= ~fsl;
    wait_chk;
    chk(fsq, fsl);
    for (int o = 2; o < 7; o++)
      rd(o);
    for (int i = 0; i < 10; i++)
    begin
      d = 8'($urandom);
      d[3] = (i >= 5);
      d = d & ~(i % 5 == 3 ? 8'h10 : (i % 5 == 4 ? 8'h20 : 8'h00));
      wr(2 + i % 5, d, CCR_SLAVE_ADDR);
      rd(2 + i % 5);
    end
    wr(7'h03, 8'h5a, 7'h12);
    wr(7'h01, 8'ha5, CCR_SLAVE_ADDR);
    rd(7'h01);
    rd(7'h03);
    blk;
    repeat (10) @(posedge mclk);
    chk(expq.size(), 0);
    wrap_up;
  end
endmodule : clock_gen_control_regs_tb
